/* logic/tsm_slot_mapper.sv */
`timescale 1ns/10ps
module tsm_slot_mapper (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// axi4-lite slave
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// receive slots from the slot assigner
	input  wire logic        rx_slot_valid,
	input  wire logic        rx_slot_sync,
	input  wire logic [7:0]  rx_slot_data,
	output logic             rx_slot_ready,
	// receive channel writes
	output logic             ch_rx_valid,
	output logic [13:0]      ch_rx_addr,
	output logic [7:0]       ch_rx_data,
	output logic [7:0]       ch_rx_mask,
	output logic [3:0]       ch_rx_count,
	// transmit slots to the slot assigner
	input  wire logic        tx_req_valid,
	input  wire logic        tx_req_sync,
	output logic             tx_req_ready,
	output logic             tx_slot_valid,
	output logic [7:0]       tx_slot_data,
	// transmit channel fetch
	output logic             tx_fetch_valid,
	output logic [13:0]      tx_fetch_addr,
	output logic [7:0]       tx_fetch_mask,
	input  wire logic        tx_fetch_ack,
	input  wire logic [7:0]  tx_fetch_data
);
	// ****************************************
	// declarations
	// ****************************************
	logic [15:0] rx_tab [tsm_pkg::TABLE_DEPTH];
	logic [15:0] tx_tab [tsm_pkg::TABLE_DEPTH];
	logic [15:0] cfg_reg, cfg_next, trap1_reg, trap1_next, trap2_reg, trap2_next;
	logic [15:0] trap3_reg, trap3_next, trap4_reg, trap4_next, smode_reg, smode_next;
	logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [15:0] aw_addr_reg, aw_addr_next, w_data_reg, w_data_next;
	logic [1:0]  w_strb_reg, w_strb_next, bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [15:0] rdata_reg, rdata_next, status;
	logic        commit, wr_rx_tab, wr_tx_tab, cfg_en;
	logic [4:0]  wr_idx;
	tsm_pkg::tsm_rx_state_t rx_state_reg, rx_state_next;
	tsm_pkg::tsm_tx_state_t tx_state_reg, tx_state_next;
	logic [4:0]  rx_idx_reg, rx_idx_next, tx_idx_reg, tx_idx_next;
	logic        rx_wait_reg, rx_wait_next, tx_wait_reg, tx_wait_next;
	logic [7:0]  rx_byte_reg, rx_byte_next;
	logic        chv_reg, chv_next;
	logic [13:0] cha_reg, cha_next, txa_reg, txa_next;
	logic [7:0]  chd_reg, chd_next, chm_reg, chm_next;
	logic [3:0]  chc_reg, chc_next;
	logic [15:0] bits_reg, bits_next;
	logic [7:0]  acc_reg, acc_next, txm_reg, txm_next, hit_reg, hit_next;
	logic        tx_adv;

	tsm_entry_if rx_ent ();
	tsm_entry_if tx_ent ();

	tsm_entry_dec u_rx_dec (.ent(rx_ent.dec));
	tsm_entry_dec u_tx_dec (.ent(tx_ent.dec));

	assign rx_ent.entry = rx_tab[rx_idx_reg];
	assign tx_ent.entry = tx_tab[tx_idx_reg];
	assign cfg_en       = cfg_reg[tsm_pkg::CFG_EN_BIT];

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction : merge

	// ****************************************
	// axi4-lite slave
	// ****************************************
	assign s_axi_awready = !aw_got_reg;
	assign s_axi_wready  = !w_got_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = {16'h0000, rdata_reg};
	assign commit        = aw_got_reg && w_got_reg && !bvalid_reg;
	assign wr_idx        = aw_addr_reg[tsm_pkg::WORD_LSB +: tsm_pkg::IDX_W];
	assign status = {2'b00, tx_state_reg != tsm_pkg::TX_IDLE, rx_state_reg != tsm_pkg::RX_IDLE,
		tx_wait_reg, rx_wait_reg, tx_idx_reg, rx_idx_reg};

	always_comb begin
		aw_got_next = aw_got_reg;
		aw_addr_next = aw_addr_reg;
		w_got_next = w_got_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg && !s_axi_bready;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		cfg_next = cfg_reg;
		trap1_next = trap1_reg;
		trap2_next = trap2_reg;
		trap3_next = trap3_reg;
		trap4_next = trap4_reg;
		smode_next = smode_reg;
		wr_rx_tab = 1'b0;
		wr_tx_tab = 1'b0;
		if (s_axi_awvalid && !aw_got_reg) begin
			aw_got_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_got_reg) begin
			w_got_next = 1'b1;
			w_data_next = s_axi_wdata[15:0];
			w_strb_next = s_axi_wstrb[1:0];
		end
		if (commit) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = tsm_pkg::RESP_OKAY;
			if (aw_addr_reg < tsm_pkg::TX_TABLE_ADDR) begin
				wr_rx_tab = 1'b1;
			end else if (aw_addr_reg < 16'(tsm_pkg::TX_TABLE_ADDR + tsm_pkg::TABLE_SPAN)) begin
				wr_tx_tab = 1'b1;
			end else if (aw_addr_reg == tsm_pkg::SMODE_ADDR) begin
				smode_next = merge(smode_reg, w_data_reg, w_strb_reg);
			end else if (aw_addr_reg == tsm_pkg::RISC_CONFIG_ADDR) begin
				cfg_next = merge(cfg_reg, w_data_reg, w_strb_reg);
			end else if (aw_addr_reg == tsm_pkg::RISC_TRAP1_ADDR) begin
				trap1_next = merge(trap1_reg, w_data_reg, w_strb_reg);
			end else if (aw_addr_reg == tsm_pkg::RISC_TRAP2_ADDR) begin
				trap2_next = merge(trap2_reg, w_data_reg, w_strb_reg);
			end else if (aw_addr_reg == tsm_pkg::RISC_TRAP3_ADDR) begin
				trap3_next = merge(trap3_reg, w_data_reg, w_strb_reg);
			end else if (aw_addr_reg == tsm_pkg::RISC_TRAP4_ADDR) begin
				trap4_next = merge(trap4_reg, w_data_reg, w_strb_reg);
			end else if (aw_addr_reg != tsm_pkg::STATUS_ADDR && aw_addr_reg != tsm_pkg::BITCNT_ADDR) begin
				bresp_next = tsm_pkg::RESP_SLVERR;
			end
		end
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rresp_next = tsm_pkg::RESP_OKAY;
			if (s_axi_araddr < tsm_pkg::TX_TABLE_ADDR) begin
				rdata_next = rx_tab[s_axi_araddr[tsm_pkg::WORD_LSB +: tsm_pkg::IDX_W]];
			end else if (s_axi_araddr < 16'(tsm_pkg::TX_TABLE_ADDR + tsm_pkg::TABLE_SPAN)) begin
				rdata_next = tx_tab[s_axi_araddr[tsm_pkg::WORD_LSB +: tsm_pkg::IDX_W]];
			end else if (s_axi_araddr == tsm_pkg::SMODE_ADDR) begin
				rdata_next = smode_reg;
			end else if (s_axi_araddr == tsm_pkg::STATUS_ADDR) begin
				rdata_next = status;
			end else if (s_axi_araddr == tsm_pkg::BITCNT_ADDR) begin
				rdata_next = bits_reg;
			end else if (s_axi_araddr == tsm_pkg::RISC_CONFIG_ADDR) begin
				rdata_next = cfg_reg;
			end else if (s_axi_araddr == tsm_pkg::RISC_TRAP1_ADDR) begin
				rdata_next = trap1_reg;
			end else if (s_axi_araddr == tsm_pkg::RISC_TRAP2_ADDR) begin
				rdata_next = trap2_reg;
			end else if (s_axi_araddr == tsm_pkg::RISC_TRAP3_ADDR) begin
				rdata_next = trap3_reg;
			end else if (s_axi_araddr == tsm_pkg::RISC_TRAP4_ADDR) begin
				rdata_next = trap4_reg;
			end else begin
				rdata_next = tsm_pkg::REG_RESET;
				rresp_next = tsm_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_got_reg <= 1'b0;
			aw_addr_reg <= tsm_pkg::REG_RESET;
			w_got_reg <= 1'b0;
			w_data_reg <= tsm_pkg::REG_RESET;
			w_strb_reg <= 2'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= tsm_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= tsm_pkg::RESP_OKAY;
			rdata_reg <= tsm_pkg::REG_RESET;
			cfg_reg <= tsm_pkg::REG_RESET;
			trap1_reg <= tsm_pkg::REG_RESET;
			trap2_reg <= tsm_pkg::REG_RESET;
			trap3_reg <= tsm_pkg::REG_RESET;
			trap4_reg <= tsm_pkg::REG_RESET;
			smode_reg <= tsm_pkg::REG_RESET;
		end else begin
			aw_got_reg <= aw_got_next;
			aw_addr_reg <= aw_addr_next;
			w_got_reg <= w_got_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			cfg_reg <= cfg_next;
			trap1_reg <= trap1_next;
			trap2_reg <= trap2_next;
			trap3_reg <= trap3_next;
			trap4_reg <= trap4_next;
			smode_reg <= smode_next;
		end
	end

	// tables: byte lanes merge over the stored entry
	always_ff @(posedge core_clk) begin
		if (wr_rx_tab) begin
			rx_tab[wr_idx] <= merge(rx_tab[wr_idx], w_data_reg, w_strb_reg);
		end
		if (wr_tx_tab) begin
			tx_tab[wr_idx] <= merge(tx_tab[wr_idx], w_data_reg, w_strb_reg);
		end
	end

	// ****************************************
	// receive engine
	// ****************************************
	assign rx_slot_ready = rx_state_reg == tsm_pkg::RX_IDLE;
	assign ch_rx_valid   = chv_reg;
	assign ch_rx_addr    = cha_reg;
	assign ch_rx_data    = chd_reg;
	assign ch_rx_mask    = chm_reg;
	assign ch_rx_count   = chc_reg;

	always_comb begin
		rx_state_next = rx_state_reg;
		rx_idx_next = rx_idx_reg;
		rx_wait_next = rx_wait_reg;
		rx_byte_next = rx_byte_reg;
		chv_next = 1'b0;
		cha_next = cha_reg;
		chd_next = chd_reg;
		chm_next = chm_reg;
		chc_next = chc_reg;
		bits_next = bits_reg;
		case (rx_state_reg)
			tsm_pkg::RX_IDLE: begin
				if (rx_slot_valid && cfg_en) begin
					if (rx_slot_sync) begin
						rx_idx_next = '0;
						rx_wait_next = 1'b0;
						rx_byte_next = rx_slot_data;
						rx_state_next = tsm_pkg::RX_RUN;
					end else if (!rx_wait_reg) begin
						rx_byte_next = rx_slot_data;
						rx_state_next = tsm_pkg::RX_RUN;
					end
				end
			end
			tsm_pkg::RX_RUN: begin
				if (rx_ent.valid) begin
					chv_next = 1'b1;
					cha_next = rx_ent.param_addr;
					chd_next = rx_byte_reg & rx_ent.mask;
					chm_next = rx_ent.mask;
					chc_next = rx_ent.bit_cnt;
					bits_next = 16'(bits_reg + {12'h000, rx_ent.bit_cnt});
				end
				if (rx_ent.wrap) begin
					rx_idx_next = '0;
					rx_wait_next = 1'b1;
					rx_state_next = tsm_pkg::RX_IDLE;
				end else begin
					rx_idx_next = 5'(rx_idx_reg + 5'h01);
					if (rx_ent.last) begin
						rx_state_next = tsm_pkg::RX_IDLE;
					end
				end
			end
			default: rx_state_next = tsm_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_state_reg <= tsm_pkg::RX_IDLE;
			rx_idx_reg <= '0;
			rx_wait_reg <= 1'b1;
			rx_byte_reg <= 8'h00;
			chv_reg <= 1'b0;
			cha_reg <= tsm_pkg::PARAM_BASE;
			chd_reg <= 8'h00;
			chm_reg <= 8'h00;
			chc_reg <= 4'h0;
			bits_reg <= tsm_pkg::REG_RESET;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_idx_reg <= rx_idx_next;
			rx_wait_reg <= rx_wait_next;
			rx_byte_reg <= rx_byte_next;
			chv_reg <= chv_next;
			cha_reg <= cha_next;
			chd_reg <= chd_next;
			chm_reg <= chm_next;
			chc_reg <= chc_next;
			bits_reg <= bits_next;
		end
	end

	// ****************************************
	// transmit engine
	// ****************************************
	assign tx_req_ready   = tx_state_reg == tsm_pkg::TX_IDLE;
	assign tx_slot_valid  = tx_state_reg == tsm_pkg::TX_DONE;
	assign tx_slot_data   = acc_reg;
	assign tx_fetch_valid = tx_state_reg == tsm_pkg::TX_FETCH;
	assign tx_fetch_addr  = txa_reg;
	assign tx_fetch_mask  = txm_reg;
	assign tx_adv = (tx_state_reg == tsm_pkg::TX_ENTRY && !tx_ent.valid) ||
		(tx_state_reg == tsm_pkg::TX_FETCH && tx_fetch_ack);

	always_comb begin
		tx_state_next = tx_state_reg;
		tx_idx_next = tx_idx_reg;
		tx_wait_next = tx_wait_reg;
		acc_next = acc_reg;
		txa_next = txa_reg;
		txm_next = txm_reg;
		hit_next = hit_reg;
		case (tx_state_reg)
			tsm_pkg::TX_IDLE: begin
				if (tx_req_valid) begin
					acc_next = tsm_pkg::SLOT_ALL_ONES;
					hit_next = 8'h00;
					tx_state_next = tsm_pkg::TX_DONE;
					if (cfg_en && tx_req_sync) begin
						tx_idx_next = '0;
						tx_wait_next = 1'b0;
						tx_state_next = tsm_pkg::TX_ENTRY;
					end else if (cfg_en && !tx_wait_reg) begin
						tx_state_next = tsm_pkg::TX_ENTRY;
					end
				end
			end
			tsm_pkg::TX_ENTRY: begin
				if (tx_ent.valid) begin
					txa_next = tx_ent.param_addr;
					txm_next = tx_ent.mask;
					tx_state_next = tsm_pkg::TX_FETCH;
				end
			end
			tsm_pkg::TX_FETCH: begin
				if (tx_fetch_ack) begin
					acc_next = (acc_reg & ~txm_reg) | (tx_fetch_data & txm_reg);
					hit_next = hit_reg | txm_reg;
				end
			end
			default: tx_state_next = tsm_pkg::TX_IDLE;
		endcase
		if (tx_adv) begin
			if (tx_ent.wrap) begin
				tx_idx_next = '0;
				tx_wait_next = 1'b1;
				tx_state_next = tsm_pkg::TX_DONE;
			end else begin
				tx_idx_next = 5'(tx_idx_reg + 5'h01);
				tx_state_next = tx_ent.last ? tsm_pkg::TX_DONE : tsm_pkg::TX_ENTRY;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_state_reg <= tsm_pkg::TX_IDLE;
			tx_idx_reg <= '0;
			tx_wait_reg <= 1'b1;
			acc_reg <= tsm_pkg::SLOT_ALL_ONES;
			txa_reg <= tsm_pkg::PARAM_BASE;
			txm_reg <= 8'h00;
			hit_reg <= 8'h00;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_idx_reg <= tx_idx_next;
			tx_wait_reg <= tx_wait_next;
			acc_reg <= acc_next;
			txa_reg <= txa_next;
			txm_reg <= txm_next;
			hit_reg <= hit_next;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence tx_final_adv;
		tx_adv && tx_ent.last && !tx_ent.wrap;
	endsequence
	sequence tx_answer;
		tx_state_reg == tsm_pkg::TX_DONE ##1 tx_state_reg == tsm_pkg::TX_IDLE;
	endsequence

	rx_discard_a: assert property (
		rx_state_reg == tsm_pkg::RX_RUN && !rx_ent.valid |=> !ch_rx_valid)
		else $error("invalid receive entry produced a write");
	rx_addr_form_a: assert property (
		ch_rx_valid |-> ch_rx_addr[5:0] == 6'h00 && ch_rx_addr >= tsm_pkg::PARAM_BASE &&
		ch_rx_addr <= tsm_pkg::PARAM_LAST)
		else $error("receive parameter address malformed");
	fw_region_a: assert property (
		tx_fetch_valid |-> tx_fetch_addr >= tsm_pkg::FW_CODE_END &&
		tx_fetch_addr < tsm_pkg::FW_DATA_START)
		else $error("fetch address inside firmware region");
	rx_count_a: assert property (
		ch_rx_valid |-> ch_rx_count == 4'($countones(ch_rx_mask)) &&
		(ch_rx_data & ~ch_rx_mask) == 8'h00)
		else $error("receive bit count or masking wrong");
	rx_wrap_a: assert property (
		rx_state_reg == tsm_pkg::RX_RUN && rx_ent.wrap |=>
		rx_idx_reg == 5'h00 && rx_wait_reg && rx_slot_ready)
		else $error("receive wrap did not return to entry zero");
	rx_chain_a: assert property (
		rx_state_reg == tsm_pkg::RX_RUN && !rx_ent.wrap && !rx_ent.last |=>
		rx_state_reg == tsm_pkg::RX_RUN && rx_idx_reg == 5'($past(rx_idx_reg) + 5'h01))
		else $error("receive chain did not stay on the slot");
	tx_ones_a: assert property (
		tx_slot_valid |-> (tx_slot_data | hit_reg) == tsm_pkg::SLOT_ALL_ONES)
		else $error("transmit idle positions not high");
	tx_wrap_a: assert property (
		tx_adv && tx_ent.wrap |=> tx_idx_reg == 5'h00 && tx_wait_reg ##1
		tx_state_reg == tsm_pkg::TX_IDLE)
		else $error("transmit wrap did not return to entry zero");
	tx_last_a: assert property (tx_final_adv |=> tx_answer)
		else $error("transmit slot not delivered after last entry");
endmodule : tsm_slot_mapper

/* logic/tsm_pkg.sv */
// ****************************************
// shared constants
// ****************************************
package tsm_pkg;
	// table geometry
	localparam int ENTRY_W     = 16;
	localparam int TABLE_DEPTH = 32;
	localparam int IDX_W       = 5;
	localparam int CHAN_W      = 5;
	localparam int SLOT_W      = 8;
	localparam int CNT_W       = 4;

	// entry field positions
	localparam int ENT_VALID_BIT   = 15;
	localparam int ENT_WRAP_BIT    = 14;
	localparam int ENT_MASK_HI_MSB = 13;
	localparam int ENT_MASK_HI_LSB = 12;
	localparam int ENT_LAST_BIT    = 11;
	localparam int ENT_CHAN_MSB    = 10;
	localparam int ENT_CHAN_LSB    = 6;
	localparam int ENT_MASK_LO_MSB = 5;
	localparam int ENT_MASK_LO_LSB = 0;

	// channel parameter addressing
	localparam int              PARAM_ADDR_W   = 11;
	localparam int              PARAM_LOW_ZERO = 6;
	localparam int              MEM_ADDR_W     = 14;
	localparam logic [13:0]     PARAM_BASE     = 14'h2400;
	localparam logic [13:0]     PARAM_LAST     = 14'h2bff;
	localparam logic [13:0]     FW_CODE_END    = 14'h0400;
	localparam logic [13:0]     DPRAM_LAST     = 14'h2fff;
	localparam logic [13:0]     FW_DATA_BYTES  = 14'h0100;
	localparam logic [13:0]     FW_DATA_START  = 14'(DPRAM_LAST - FW_DATA_BYTES + 14'h0001);

	// register bus map
	localparam int          ADDR_W           = 16;
	localparam logic [13:0] RISC_CONFIG_IDX  = 14'h09c4;
	localparam logic [13:0] RISC_TRAP1_IDX   = 14'h09cc;
	localparam logic [13:0] RISC_TRAP2_IDX   = 14'h09ce;
	localparam logic [13:0] RISC_TRAP3_IDX   = 14'h09d0;
	localparam logic [13:0] RISC_TRAP4_IDX   = 14'h09d2;
	localparam logic [15:0] RISC_CONFIG_ADDR = {RISC_CONFIG_IDX, 2'b00};
	localparam logic [15:0] RISC_TRAP1_ADDR  = {RISC_TRAP1_IDX, 2'b00};
	localparam logic [15:0] RISC_TRAP2_ADDR  = {RISC_TRAP2_IDX, 2'b00};
	localparam logic [15:0] RISC_TRAP3_ADDR  = {RISC_TRAP3_IDX, 2'b00};
	localparam logic [15:0] RISC_TRAP4_ADDR  = {RISC_TRAP4_IDX, 2'b00};
	localparam logic [15:0] RX_TABLE_ADDR    = 16'h0000;
	localparam logic [15:0] TX_TABLE_ADDR    = 16'h0080;
	localparam logic [15:0] TABLE_SPAN       = 16'h0080;
	localparam logic [15:0] SMODE_ADDR       = 16'h0100;
	localparam logic [15:0] STATUS_ADDR      = 16'h0104;
	localparam logic [15:0] BITCNT_ADDR      = 16'h0108;
	localparam int          WORD_LSB         = 2;

	// register values
	localparam int          CFG_EN_BIT    = 1;
	localparam logic [15:0] REG_RESET     = 16'h0000;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	localparam logic [7:0]  SLOT_ALL_ONES = 8'hff;

	typedef enum logic [1:0] {RX_IDLE, RX_RUN} tsm_rx_state_t;
	typedef enum logic [1:0] {TX_IDLE, TX_ENTRY, TX_FETCH, TX_DONE} tsm_tx_state_t;
endpackage : tsm_pkg

/* logic/tsm_entry_if.sv */
`timescale 1ns/10ps
// ****************************************
// decoded table entry
// ****************************************
interface tsm_entry_if;
	logic [15:0] entry;
	logic        valid;
	logic        wrap;
	logic        last;
	logic [4:0]  chan;
	logic [7:0]  mask;
	logic [13:0] param_addr;
	logic [3:0]  bit_cnt;

	modport dec  (input entry, output valid, wrap, last, chan, mask, param_addr, bit_cnt);
	modport user (output entry, input valid, wrap, last, chan, mask, param_addr, bit_cnt);
endinterface : tsm_entry_if

/* logic/tsm_entry_dec.sv */
`timescale 1ns/10ps
// ****************************************
// table entry decoder
// ****************************************
module tsm_entry_dec (
	// entry in, fields out
	tsm_entry_if.dec ent
);
	logic [10:0] ptr;

	assign ent.valid = ent.entry[tsm_pkg::ENT_VALID_BIT];
	assign ent.wrap  = ent.entry[tsm_pkg::ENT_WRAP_BIT];
	assign ent.last  = ent.entry[tsm_pkg::ENT_LAST_BIT];
	assign ent.chan  = ent.entry[tsm_pkg::ENT_CHAN_MSB:tsm_pkg::ENT_CHAN_LSB];
	assign ent.mask  = {ent.entry[tsm_pkg::ENT_MASK_HI_MSB:tsm_pkg::ENT_MASK_HI_LSB],
		ent.entry[tsm_pkg::ENT_MASK_LO_MSB:tsm_pkg::ENT_MASK_LO_LSB]};
	// selector on top, low bits forced to zero
	assign ptr = {ent.chan, {tsm_pkg::PARAM_LOW_ZERO{1'b0}}};
	assign ent.param_addr = 14'(tsm_pkg::PARAM_BASE + {3'h0, ptr});
	assign ent.bit_cnt = 4'($countones(ent.mask));
endmodule : tsm_entry_dec

/* testbench/tsm_far_model.sv */
`timescale 1ns/10ps
// ****
// channel fetch responder
// ****
module tsm_far_model (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// fetch side
	input  wire logic       tx_fetch_valid,
	input  wire logic [7:0] fill,
	input  wire logic [3:0] delay,
	output logic            tx_fetch_ack,
	output logic [7:0]      tx_fetch_data
);
	logic [3:0] wait_cnt;
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_cnt <= 4'h0;
			tx_fetch_ack <= 1'b0;
			tx_fetch_data <= 8'h00;
		end else if (tx_fetch_valid && !tx_fetch_ack && wait_cnt == delay) begin
			wait_cnt <= 4'h0;
			tx_fetch_ack <= 1'b1;
			tx_fetch_data <= fill;
		end else begin
			tx_fetch_ack <= 1'b0;
			tx_fetch_data <= ~tx_fetch_data;
			if (tx_fetch_valid && !tx_fetch_ack)
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : tsm_far_model

/* testbench/tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
	// ****
	// bench
	// ****
	logic        core_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, rx_slot_valid, rx_slot_sync, rx_slot_ready, ch_rx_valid;
	logic        tx_req_valid, tx_req_sync, tx_req_ready, tx_slot_valid, tx_fetch_valid, tx_fetch_ack;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  rx_slot_data, ch_rx_data, ch_rx_mask, tx_slot_data, tx_fetch_mask, tx_fetch_data;
	logic [13:0] ch_rx_addr, tx_fetch_addr;
	logic [3:0]  ch_rx_count, delay;
	logic [33:0] rxq[$];
	logic [7:0]  txq[$], fill;
	logic [15:0] tv[4] = '{16'h8074, 16'h8054, 16'h92f2, 16'h9097};
	int          errors, check_count;
	tsm_slot_mapper u_tsm_slot_mapper (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .rx_slot_valid, .rx_slot_sync, .rx_slot_data, .rx_slot_ready,
		.ch_rx_valid, .ch_rx_addr, .ch_rx_data, .ch_rx_mask, .ch_rx_count, .tx_req_valid,
		.tx_req_sync, .tx_req_ready, .tx_slot_valid, .tx_slot_data, .tx_fetch_valid,
		.tx_fetch_addr, .tx_fetch_mask, .tx_fetch_ack, .tx_fetch_data);
	tsm_far_model u_tsm_far_model (.core_clk, .reset_n, .tx_fetch_valid, .fill, .delay,
		.tx_fetch_ack, .tx_fetch_data);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (ch_rx_valid) rxq.push_back({ch_rx_addr, ch_rx_data, ch_rx_mask, ch_rx_count});
		if (tx_slot_valid) txq.push_back(tx_slot_data);
		if (tx_fetch_valid && tx_fetch_ack)
			`CHK("fetch", 22'h248_00f, {tx_fetch_addr, tx_fetch_mask})
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		logic ta, tw, da, dw;
		@(posedge core_clk);
		{da, dw} = 2'b00;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(da && dw)) begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			da |= ta;
			dw |= tw;
		end
		do @(negedge core_clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		@(posedge core_clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(negedge core_clk); while (!s_axi_arready);
		@(posedge core_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge core_clk); while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		@(posedge core_clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_slot_valid,
			rx_slot_sync, tx_req_valid, tx_req_sync, s_axi_awaddr, s_axi_araddr, s_axi_wdata,
			rx_slot_data, fill, delay, reset_n} = '0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(tsm_pkg::RISC_CONFIG_ADDR);
		`CHK("config reset", 34'h0, {d, r})
		for (int i = 0; i < 4; i++) begin
			wr(tsm_pkg::RISC_TRAP1_ADDR + 16'(i * 8), tv[i]);
			`CHK("trap write", tsm_pkg::RESP_OKAY, r)
			rd(tsm_pkg::RISC_TRAP1_ADDR + 16'(i * 8));
			`CHK("trap", {16'h0000, tv[i], 2'b00}, {d, r})
		end
		wr(tsm_pkg::RX_TABLE_ADDR, 16'hb9ff);
		wr(tsm_pkg::RX_TABLE_ADDR + 16'h0004, 16'h80c3);
		wr(tsm_pkg::RX_TABLE_ADDR + 16'h0008, 16'h0000);
		wr(tsm_pkg::RX_TABLE_ADDR + 16'h000c, 16'hf940);
		wr(tsm_pkg::TX_TABLE_ADDR, 16'h0000);
		wr(tsm_pkg::TX_TABLE_ADDR + 16'h0004, 16'hc88f);
		wr(tsm_pkg::SMODE_ADDR, 16'h07a0);
		wr(tsm_pkg::RISC_CONFIG_ADDR, 16'h0002);
		rd(16'h0200);
		`CHK("unmapped", tsm_pkg::RESP_SLVERR, r)
		for (int s = 0; s < 2; s++) begin
			@(posedge core_clk);
			{rx_slot_valid, rx_slot_sync, rx_slot_data} <= {1'b1, s == 0, s[0] ? 8'ha5 : 8'h3c};
			do @(negedge core_clk); while (!rx_slot_ready);
			@(posedge core_clk);
			{rx_slot_valid, rx_slot_sync} <= 2'b00;
		end
		wait (rxq.size() == 3);
		`CHK("rx whole", {14'h25c0, 8'h3c, 8'hff, 4'h8}, rxq[0])
		`CHK("rx sub a", {14'h24c0, 8'h01, 8'h03, 4'h2}, rxq[1])
		`CHK("rx sub b", {14'h2540, 8'h80, 8'hc0, 4'h2}, rxq[2])
		rd(tsm_pkg::BITCNT_ADDR);
		`CHK("bit total", {32'h0000_000c, tsm_pkg::RESP_OKAY}, {d, r})
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			{tx_req_valid, tx_req_sync, fill, delay} <= {2'b11, k[0] ? 8'hc3 : 8'h5a, 4'(k * 3)};
			do @(negedge core_clk); while (!tx_req_ready);
			@(posedge core_clk);
			{tx_req_valid, tx_req_sync} <= 2'b00;
			wait (txq.size() == k + 1);
			`CHK("tx slot", (fill & 8'h0f) | 8'hf0, txq[k])
		end
		print_verdict();
	end
	initial begin
		#100000;
		errors++;
		print_verdict();
	end
endmodule : tb
